// ===== design/odsp_pkg.sv
// Constants shared by the octal DAC serial load port.
// Assumes a single core clock; pins arrive asynchronous to it.
// What this block does
// [RULE1] Shift serial_in on clock rise while loading low
// [RULE2] Each shift also moves far bit to serial_out
// [RULE3] serial_out repeats serial_in twelve shifts later
// [RULE4] Strobe rise copies word into addressed channel
// [RULE5] Preset low forces all channels to 80H
// [RULE6] Word holds channel address and data bits
// [RULE7] Daisy chain: out feeds next device input
// [RULE8] Four address then eight data, MSB first
// ---------------------------------------------------------------
// Package
// ---------------------------------------------------------------
package odsp_pkg;
    localparam int SR_WIDTH = 12;
    localparam int ADDR_WIDTH = 4;
    localparam int CODE_WIDTH = 8;
    localparam int NUM_CHANNELS = 8;
    localparam int ADDR_MSB = 11;
    localparam int ADDR_LSB = 8;
    localparam int CODE_MSB = 7;
    localparam int CODE_LSB = 0;
    localparam logic [7:0] PRESET_CODE = 8'h80;
    localparam logic [7:0] RESET_CODE = 8'h80;
    localparam logic [11:0] SR_RESET = 12'h000;
    localparam logic SDO_RESET = 1'b0;
    localparam int SYNC_STAGES = 2;
    localparam int NUM_PINS = 4;
    localparam int PIN_CLK = 0;
    localparam int PIN_DATA = 1;
    localparam int PIN_LOAD = 2;
    localparam int PIN_PRESET = 3;
endpackage : odsp_pkg

// ===== design/odsp_pins_if.sv
// Interface carrying raw pin levels to the synchroniser and back.
// Assumes both modports sit on the core clock domain side.
interface odsp_pins_if;
    logic [odsp_pkg::NUM_PINS-1:0] raw;
    logic [odsp_pkg::NUM_PINS-1:0] synced;
    modport sync_side (input raw, output synced);
    modport core_side (output raw, input synced);
endinterface : odsp_pins_if

// ===== design/odsp_sync.sv
// Two flip-flop synchroniser for all serial port pins.
// Assumes raw pins are asynchronous to core_clk_i.
module odsp_sync (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // Pins
    odsp_pins_if.sync_side pins
);
    logic [odsp_pkg::NUM_PINS-1:0] meta_r;
    logic [odsp_pkg::NUM_PINS-1:0] sync_r;

    // One synchroniser chain per pin
    genvar gi;
    generate
        for (gi = 0; gi < odsp_pkg::NUM_PINS; gi++) begin : g_pin
            always_ff @(posedge core_clk_i) begin
                if (!reset_n_i) begin
                    meta_r[gi] <= 1'b0;
                    sync_r[gi] <= 1'b0;
                end else begin
                    meta_r[gi] <= pins.raw[gi];
                    sync_r[gi] <= meta_r[gi];
                end
            end
        end
    endgenerate

    assign pins.synced = sync_r;
endmodule : odsp_sync

// ===== design/odsp_top.sv
// Serial load port of an eight channel DAC: shift register,
// daisy chain output and eight channel code registers.
// Assumes pins are asynchronous; serial clock is sampled, not used.
// Assumes core_clk_i runs well above the serial clock, so each serial
// clock level lasts at least two core cycles and no edge is lost.
// Channel n appears on dac_code_o[8n+7:8n].
module odsp_top (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // Serial pins
    input wire logic serial_clk_i,
    input wire logic serial_in_i,
    input wire logic dac_load_strobe_i,
    input wire logic preset_n_i,
    // Outputs
    output logic serial_out_o,
    output logic [63:0] dac_code_o
);
    // ---------------------------------------------------------------
    // Pin synchronisation
    // ---------------------------------------------------------------
    odsp_pins_if pins_if ();

    // Every pin, data included, passes the same two stages, so data and
    // clock levels stay aligned to one core edge.
    // Raw pin gather
    assign pins_if.raw[odsp_pkg::PIN_CLK] = serial_clk_i;
    assign pins_if.raw[odsp_pkg::PIN_DATA] = serial_in_i;
    assign pins_if.raw[odsp_pkg::PIN_LOAD] = dac_load_strobe_i;
    assign pins_if.raw[odsp_pkg::PIN_PRESET] = preset_n_i;

    // Two stage synchroniser shared by all four pins
    odsp_sync u_sync (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .pins(pins_if.sync_side)
    );

    logic clk_s;
    logic din_s;
    logic load_s;
    logic preset_n_s;
    logic clk_prev_r;
    logic load_prev_r;
    logic shift_evt;
    logic load_evt;
    logic preset_act;

    // Synchronised levels
    assign clk_s = pins_if.synced[odsp_pkg::PIN_CLK];
    assign din_s = pins_if.synced[odsp_pkg::PIN_DATA];
    assign load_s = pins_if.synced[odsp_pkg::PIN_LOAD];
    assign preset_n_s = pins_if.synced[odsp_pkg::PIN_PRESET];

    // Edge history of clock and strobe
    // Reset to the idle pin levels, so no false edge follows reset
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            clk_prev_r <= 1'b0;
            load_prev_r <= 1'b0;
        end else begin
            clk_prev_r <= clk_s;
            load_prev_r <= load_s;
        end
    end

    // Event decode
    assign preset_act = !preset_n_s;
    // Blocked while the strobe is high or preset is held low
    assign shift_evt = clk_s && !clk_prev_r && // [RULE1]
        !load_s && preset_n_s;
    assign load_evt = load_s && !load_prev_r;

    // ---------------------------------------------------------------
    // Shift register and serial output
    // ---------------------------------------------------------------
    logic [odsp_pkg::SR_WIDTH-1:0] sr_r;
    logic serial_out_r;

    // Input shift register, MSB first toward the far end
    // Preset freezes it; only the code bank is forced
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            sr_r <= odsp_pkg::SR_RESET;
        end else if (shift_evt) begin
            sr_r <= {sr_r[odsp_pkg::SR_WIDTH-2:0], din_s}; // [RULE1]
        end
    end

    // Far end bit leaves on each shift, twelve shifts behind input
    // Resets low so a chained device sees a quiet input
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            serial_out_r <= odsp_pkg::SDO_RESET;
        end else if (shift_evt) begin
            serial_out_r <= sr_r[odsp_pkg::SR_WIDTH-1]; // [RULE2] [RULE3]
        end
    end

    assign serial_out_o = serial_out_r;

    // ---------------------------------------------------------------
    // Channel code registers
    // ---------------------------------------------------------------
    logic [odsp_pkg::CODE_WIDTH-1:0] dac_r [odsp_pkg::NUM_CHANNELS];
    logic [odsp_pkg::ADDR_WIDTH-1:0] word_addr;
    logic [odsp_pkg::CODE_WIDTH-1:0] word_code;

    // Word split: address high, code low
    // Addresses 8 to 15 match no channel, so such a load changes nothing
    assign word_addr = sr_r[odsp_pkg::ADDR_MSB:odsp_pkg::ADDR_LSB]; // [RULE6]
    assign word_code = sr_r[odsp_pkg::CODE_MSB:odsp_pkg::CODE_LSB]; // [RULE8]

    // One code register per channel; preset wins over a load
    genvar ch;
    generate
        for (ch = 0; ch < odsp_pkg::NUM_CHANNELS; ch++) begin : g_ch
            always_ff @(posedge core_clk_i) begin
                if (!reset_n_i) begin
                    dac_r[ch] <= odsp_pkg::RESET_CODE;
                end else if (preset_act) begin
                    dac_r[ch] <= odsp_pkg::PRESET_CODE; // [RULE5]
                end else if (load_evt &&
                             word_addr == odsp_pkg::ADDR_WIDTH'(ch)) begin
                    dac_r[ch] <= word_code; // [RULE4] [RULE8]
                end
            end
            assign dac_code_o[ch*8 +: 8] = dac_r[ch];
        end
    endgenerate

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    logic [odsp_pkg::SR_WIDTH:0] hist_r;
    logic all_preset;

    // Reference history of shifted-in bits
    // Kept apart from sr_r so the twelve-shift delay is checked, not copied
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            hist_r <= '0;
        end else if (shift_evt) begin
            hist_r <= {hist_r[odsp_pkg::SR_WIDTH-1:0], din_s};
        end
    end

    // Whole code bank checks
    assign all_preset = (dac_code_o == {8{odsp_pkg::PRESET_CODE}});

    // Checks run on the core clock and sleep while reset is held
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence shift_seq;
        shift_evt ##1 1'b1;
    endsequence

    sequence valid_load_seq;
        load_evt && preset_n_s && word_addr < 4'h8;
    endsequence

    // Clock rise that arrives while the strobe is high
    sequence refused_rise_seq;
        clk_s && !clk_prev_r && load_s;
    endsequence

    // Preset seen low on two samples in a row
    sequence preset_hold_seq;
        preset_act ##1 preset_act;
    endsequence

    // Shift path
    shift_update_a: assert property (shift_evt |=> // [RULE1]
        sr_r == {$past(sr_r[10:0]), $past(din_s)})
        else $error("shift register did not take input bit");
    shift_idle_a: assert property (!shift_evt |=> $stable(sr_r)) // [RULE1]
        else $error("shift register moved without a clock rise");
    sdo_update_a: assert property (shift_evt |=> // [RULE2]
        serial_out_o == $past(sr_r[11]))
        else $error("serial output missed far end bit");
    sdo_hold_a: assert property (!shift_evt |=> // [RULE2]
        $stable(serial_out_o))
        else $error("serial output changed between shifts");
    sdo_delay_a: assert property (shift_seq |-> // [RULE3]
        serial_out_o == hist_r[odsp_pkg::SR_WIDTH])
        else $error("serial output not twelve shifts behind input");
    shift_refused_a: assert property (refused_rise_seq |=> // [RULE1]
        $stable(sr_r) && $stable(serial_out_o))
        else $error("shift happened while strobe high");
    preset_freeze_a: assert property (preset_act |=> // [RULE1]
        $stable(sr_r) && $stable(serial_out_o))
        else $error("preset disturbed the shift register");

    // Code bank
    load_write_a: assert property (valid_load_seq |=> // [RULE4]
        dac_r[$past(word_addr[2:0])] == $past(word_code))
        else $error("addressed channel not loaded");
    preset_all_a: assert property (preset_act |=> all_preset) // [RULE5]
        else $error("preset did not force midscale");
    preset_hold_a: assert property (preset_hold_seq |-> all_preset) // [RULE5]
        else $error("channels not midscale while preset held");
    preset_wins_a: assert property (load_evt && preset_act |=> // [RULE5]
        all_preset)
        else $error("load overrode a held preset");
    bad_addr_a: assert property (load_evt && word_addr >= 4'h8 // [RULE8]
        && !preset_act |=> $stable(dac_code_o))
        else $error("unused address changed a channel");
    no_load_a: assert property (!load_evt && !preset_act // [RULE4]
        |=> $stable(dac_code_o))
        else $error("channel changed without strobe rise");
    load_keep_sr_a: assert property (load_evt && !shift_evt |=> // [RULE4]
        $stable(sr_r))
        else $error("load disturbed the shift register");

    // Channels other than the addressed one keep their code on a load
    genvar ca;
    generate
        for (ca = 0; ca < odsp_pkg::NUM_CHANNELS; ca++) begin : g_keep
            chan_keep_a: assert property (load_evt && // [RULE6]
                !preset_act && word_addr != odsp_pkg::ADDR_WIDTH'(ca) |=>
                $stable(dac_r[ca]))
                else $error("load changed a channel it did not address");
        end
    endgenerate
endmodule : odsp_top

// ===== bench/odsp_host.sv
// Host model for the serial load port: shift clock, data, strobe, preset.
// Assumes the bench calls one task at a time; link clock period 125 ns.
module odsp_host (
    // Pins to the device
    output logic sclk_o,
    output logic serial_in_o,
    output logic load_o,
    output logic pre_n_o,
    // Chained output back from the device
    input wire logic so_i
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle levels: clock and strobe low, preset released
    initial begin
        sclk_o = 1'b0;
        serial_in_o = 1'b0;
        load_o = 1'b0;
        pre_n_o = 1'b1;
    end
    // Shift a word MSB first; data flips once its hold time is over
    task automatic shift_word(input logic [11:0] w, output logic [11:0] got);
        for (int i = 11; i >= 0; i--) begin
            serial_in_o = w[i];
            #62.5 sclk_o = 1'b1;
            #20 serial_in_o = ~w[i];
            #42.5 sclk_o = 1'b0;
            got[i] = so_i;
        end
    endtask : shift_word
    // Strobe pulse after a whole word has been shifted
    task automatic load_pulse();
        #100 load_o = 1'b1;
        #100 load_o = 1'b0;
        #100;
    endtask : load_pulse
    // Preset assert, returns with preset still low
    task automatic preset_low();
        pre_n_o = 1'b0;
        #100;
    endtask : preset_low
    // Preset release; waits until the device has seen it
    task automatic preset_high();
        pre_n_o = 1'b1;
        #100;
    endtask : preset_high
    // Clock pulse with the strobe held high; the device must not shift
    task automatic clock_under_load();
        load_o = 1'b1;
        serial_in_o = 1'b1;
        #100 sclk_o = 1'b1;
        #62.5 sclk_o = 1'b0;
        #100 load_o = 1'b0;
        #100;
    endtask : clock_under_load
endmodule : odsp_host

// ===== bench/odsp_top_tb.sv
// Self-checking bench for the serial load port top level.
// Assumes the host model drives every serial pin.
module odsp_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic sclk, serial_in, load, pre_n, so;
    logic [63:0] codes;
    logic [63:0] exp_codes;
    logic [11:0] got;
    int fail_count = 0;
    int checked = 0;
    odsp_host u_host (.sclk_o(sclk), .serial_in_o(serial_in), .load_o(load),
        .pre_n_o(pre_n), .so_i(so));
    odsp_top u_dut (.core_clk_i(core_clk), .reset_n_i(reset_n),
        .serial_clk_i(sclk), .serial_in_i(serial_in), .dac_load_strobe_i(load),
        .preset_n_i(pre_n), .serial_out_o(so), .dac_code_o(codes));
    // Core clock, 8 ns period
    initial forever #4 core_clk = ~core_clk;
    // Compare and count
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // Verdict and end of run
    task automatic conclude();
        if (fail_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude
    // Every address loaded once; unused ones must change nothing
    task automatic load_all();
        for (int a = 0; a < 16; a++) begin
            u_host.shift_word({a[3:0], a[3:0], 4'h3}, got);
            u_host.load_pulse();
            if (a < 8) exp_codes[8*a +: 8] = {a[3:0], 4'h3};
            chk(codes, exp_codes);
        end
    endtask : load_all
    // Second word pushes the first out twelve shifts later
    task automatic chain();
        u_host.shift_word(12'hA5C, got);
        chk({52'h0, got}, 64'hFF3);
        u_host.shift_word(12'h3E1, got);
        chk({52'h0, got}, 64'hA5C);
        u_host.load_pulse();
        exp_codes[31:24] = 8'hE1;
        chk(codes, exp_codes);
    endtask : chain
    // Preset low forces midscale through a load; word survives it
    task automatic preset();
        u_host.preset_low();
        u_host.load_pulse();
        exp_codes = {8{8'h80}};
        chk(codes, exp_codes);
        u_host.preset_high();
        u_host.load_pulse();
        exp_codes[31:24] = 8'hE1;
        chk(codes, exp_codes);
    endtask : preset
    // A clock rise under a high strobe must leave the word in place
    task automatic strobe_block();
        u_host.clock_under_load();
        u_host.load_pulse();
        chk(codes, exp_codes);
    endtask : strobe_block
    // Out of reset: channels midscale, chain output low
    task automatic after_reset();
        repeat (4) @(negedge core_clk);
        chk(codes, exp_codes);
        chk({63'h0, so}, 64'h0);
    endtask : after_reset
    // Main sequence
    initial begin
        exp_codes = {8{8'h80}};
        repeat (8) @(negedge core_clk);
        reset_n = 1'b1;
        after_reset();
        load_all();
        chain();
        preset();
        strobe_block();
        conclude();
    end
    // Watchdog
    initial begin
        #300000;
        fail_count++;
        conclude();
    end
endmodule : odsp_top_tb
